// ===== shared/ptu_defs.svh
`ifndef PTU_DEFS_SVH
`define PTU_DEFS_SVH

// Register offsets
`define REG_CTRL      4'h0
`define REG_PTR_LO    4'h4
`define REG_PTR_HI    4'h8
`define REG_STAT      4'hc

// Control register fields
`define CTRL_WIDE     0
`define CTRL_PAGE_EN  4
`define CTRL_RESET    32'h0000_0000

// Descriptor flag bits
`define FLAG_RO       0
`define FLAG_RW       1
`define FLAG_EX       2

// Descriptor word indices
`define WORD_LBASE    3'd0
`define WORD_PBASE    3'd1
`define WORD_SIZE     3'd2
`define WORD_FLAGS    3'd3
`define WORD_NEXT     3'd4

// Byte stride between descriptor words
`define WORD_STEP32   64'h0000_0000_0000_0004
`define WORD_STEP64   64'h0000_0000_0000_0008

// Fault codes
`define FAULT_NONE    2'h0
`define FAULT_PAGE    2'h1
`define FAULT_PERM    2'h2

`endif

// ===== shared/ptu_pkg.sv
package ptu_pkg;

  typedef enum logic [1:0] {
    ACC_READ  = 2'b00,
    ACC_WRITE = 2'b01,
    ACC_FETCH = 2'b10
  } acc_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_FETCH  = 3'b001,
    ST_CHECK  = 3'b010,
    ST_ACCESS = 3'b011,
    ST_DONE   = 3'b100
  } walk_state_t;

  typedef struct packed {
    logic [63:0] addr;
    acc_kind_t   kind;
    logic [63:0] wdata;
  } xlate_req_t;

  typedef struct packed {
    logic [1:0]  fault;
    logic [63:0] paddr;
    logic [63:0] rdata;
  } xlate_res_t;

endpackage

// ===== design/paging_translation_unit.sv
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`include "ptu_defs.svh"

module paging_translation_unit
  import ptu_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  input  wire logic        req_valid_i,
  input  wire xlate_req_t  req_i,
  output logic             req_ready_o,
  output logic             done_o,
  output xlate_res_t       res_o,
  output logic             mem_req_o,
  output logic             mem_we_o,
  output logic      [63:0] mem_addr_o,
  output logic      [63:0] mem_wdata_o,
  input  wire logic [63:0] mem_rdata_i,
  input  wire logic        mem_ack_i
);

  walk_state_t st;
  logic [31:0] ctrl;
  logic [63:0] chain_ptr;
  logic [1:0]  last_fault;
  xlate_req_t  cur;
  logic [63:0] lbase;
  logic [63:0] pbase;
  logic [63:0] rsize;
  logic [63:0] flags;
  logic [63:0] nxt;
  logic [63:0] first_ptr;
  logic [2:0]  widx;
  logic        wide;
  logic        page_en;
  logic        hit;
  logic        perm_ok;
  logic        chain_end;
  logic [63:0] step;
  logic [63:0] xlated;

  assign wide    = ctrl[`CTRL_WIDE];
  assign page_en = ctrl[`CTRL_PAGE_EN];
  assign step    = wide ? `WORD_STEP64 : `WORD_STEP32;

  // Narrow mode keeps only the low word of every address and field
  function automatic logic [63:0] trim(input logic [63:0] v, input logic w);
    trim = w ? v : {32'h0, v[31:0]};
  endfunction

  // --------------------------------------------------------------
  // Lookup and permission decode
  // --------------------------------------------------------------
  // range test
  assign hit = (cur.addr > lbase) && (cur.addr < trim(lbase + rsize, wide));

  assign chain_end = (nxt == 64'h0) || (nxt == first_ptr);

  assign xlated = trim(pbase + (cur.addr - lbase), wide);

  always_comb begin
    perm_ok = 1'b0;
    if (!(flags[`FLAG_RO] && flags[`FLAG_RW])) begin
      case (cur.kind)
        ACC_READ:  perm_ok = flags[`FLAG_RO] || flags[`FLAG_RW];
        ACC_WRITE: perm_ok = flags[`FLAG_RW];
        ACC_FETCH: perm_ok = flags[`FLAG_EX];
        default:   perm_ok = 1'b0;
      endcase
    end
  end

  // --------------------------------------------------------------
  // Register port
  // --------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      ctrl      <= `CTRL_RESET;
      chain_ptr <= 64'h0;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `REG_CTRL:   ctrl <= reg_wdata_i;
        `REG_PTR_LO: chain_ptr[31:0] <= reg_wdata_i;
        `REG_PTR_HI: chain_ptr[63:32] <= reg_wdata_i;
        default:     ;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      reg_rdata_o <= 32'h0;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `REG_CTRL:   reg_rdata_o <= ctrl;
        `REG_PTR_LO: reg_rdata_o <= chain_ptr[31:0];
        `REG_PTR_HI: reg_rdata_o <= chain_ptr[63:32];
        `REG_STAT:   reg_rdata_o <= {29'h0, last_fault, (st != ST_IDLE)};
        default:     reg_rdata_o <= 32'h0;
      endcase
    end else begin
      reg_rdata_o <= 32'h0;
    end
  end

  // --------------------------------------------------------------
  // Walk state machine
  // --------------------------------------------------------------
  assign req_ready_o = (st == ST_IDLE);
  assign done_o      = (st == ST_DONE);
  assign mem_req_o   = (st == ST_FETCH) || (st == ST_ACCESS);
  assign mem_we_o    = (st == ST_ACCESS) && (cur.kind == ACC_WRITE);

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      st          <= ST_IDLE;
      cur         <= '0;
      first_ptr   <= 64'h0;
      widx        <= `WORD_LBASE;
      mem_addr_o  <= 64'h0;
      mem_wdata_o <= 64'h0;
      res_o       <= '0;
    end else begin
      case (st)
        ST_IDLE: begin
          if (req_valid_i) begin
            cur.addr    <= trim(req_i.addr, wide);
            cur.kind    <= req_i.kind;
            cur.wdata   <= req_i.wdata;
            mem_wdata_o <= trim(req_i.wdata, wide);
            res_o       <= '0;
            if (!page_en) begin
              mem_addr_o <= trim(req_i.addr, wide);
              st         <= ST_ACCESS;
            end else begin
              mem_addr_o <= trim(chain_ptr, wide);
              first_ptr  <= trim(chain_ptr, wide);
              widx       <= `WORD_LBASE;
              st         <= ST_FETCH;
            end
          end
        end
        ST_FETCH: begin
          if (mem_ack_i) begin
            mem_addr_o <= mem_addr_o + step;
            widx       <= widx + 3'd1;
            if (widx == `WORD_NEXT) begin
              st <= ST_CHECK;
            end
          end
        end
        ST_CHECK: begin
          if (hit) begin
            if (perm_ok) begin
              mem_addr_o <= xlated;
              res_o.paddr <= xlated;
              st         <= ST_ACCESS;
            end else begin
              res_o.fault <= `FAULT_PERM;
              st          <= ST_DONE;
            end
          end else if (chain_end) begin
            res_o.fault <= `FAULT_PAGE;
            st          <= ST_DONE;
          end else begin
            mem_addr_o <= nxt;
            widx       <= `WORD_LBASE;
            st         <= ST_FETCH;
          end
        end
        ST_ACCESS: begin
          if (mem_ack_i) begin
            res_o.paddr <= mem_addr_o;
            res_o.rdata <= trim(mem_rdata_i, wide);
            st          <= ST_DONE;
          end
        end
        ST_DONE: begin
          st <= ST_IDLE;
        end
        default: st <= ST_IDLE;
      endcase
    end
  end

  // Descriptor capture; the previous pointer word is not needed
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      lbase <= 64'h0;
      pbase <= 64'h0;
      rsize <= 64'h0;
      flags <= 64'h0;
      nxt   <= 64'h0;
    end else if (st == ST_FETCH && mem_ack_i) begin
      case (widx)
        `WORD_LBASE: lbase <= trim(mem_rdata_i, wide);
        `WORD_PBASE: pbase <= trim(mem_rdata_i, wide);
        `WORD_SIZE:  rsize <= trim(mem_rdata_i, wide);
        `WORD_FLAGS: flags <= trim(mem_rdata_i, wide);
        `WORD_NEXT:  nxt   <= trim(mem_rdata_i, wide);
        default:     ;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      last_fault <= `FAULT_NONE;
    end else if (st == ST_DONE) begin
      last_fault <= res_o.fault;
    end
  end

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  a_bypass_direct: assert property (
    (st == ST_IDLE && req_valid_i && !page_en)
      |=> (st == ST_ACCESS && mem_addr_o == $past(trim(req_i.addr, wide))))
    else $error("unpaged access not sent straight through");

  a_walk_start: assert property (
    (st == ST_IDLE && req_valid_i && page_en)
      |=> (st == ST_FETCH && mem_addr_o == $past(trim(chain_ptr, wide))))
    else $error("walk did not start at chain pointer");

  a_word_stride: assert property (
    (st == ST_FETCH && mem_ack_i) |=> (mem_addr_o == $past(mem_addr_o) + $past(step)))
    else $error("descriptor word stride wrong");

  a_perm_both: assert property (
    (st == ST_CHECK && hit && flags[`FLAG_RO] && flags[`FLAG_RW])
      |=> (done_o && res_o.fault == `FAULT_PERM))
    else $error("both access flags set without permission fault");

  a_write_needs_rw: assert property (
    (st == ST_CHECK && hit && cur.kind == ACC_WRITE && !flags[`FLAG_RW])
      |=> (done_o && res_o.fault == `FAULT_PERM))
    else $error("write allowed without read/write flag");

  a_follow_next: assert property (
    (st == ST_CHECK && !hit && !chain_end)
      |=> (st == ST_FETCH && mem_addr_o == $past(nxt)))
    else $error("walk did not follow next pointer");

  a_miss_fault: assert property (
    (st == ST_CHECK && !hit && chain_end) |=> (done_o && res_o.fault == `FAULT_PAGE))
    else $error("exhausted chain without page fault");

  a_translate: assert property (
    (st == ST_CHECK && hit && perm_ok)
      |=> (st == ST_ACCESS && mem_addr_o == $past(xlated)))
    else $error("physical address not base plus offset");

  a_no_faulty_access: assert property (
    (done_o && res_o.fault != `FAULT_NONE) |-> ($past(st) == ST_CHECK))
    else $error("memory accessed on a faulting lookup");

  a_done_pulse: assert property (
    done_o |=> (!done_o && req_ready_o))
    else $error("done longer than one cycle");

  a_read_perm: assert property (
    (st == ST_CHECK && hit && cur.kind == ACC_READ && !flags[`FLAG_RO] && !flags[`FLAG_RW])
      |=> (done_o && res_o.fault == `FAULT_PERM))
    else $error("read allowed without a read flag");

  a_fetch_perm: assert property (
    (st == ST_CHECK && hit && cur.kind == ACC_FETCH && !flags[`FLAG_EX])
      |=> (done_o && res_o.fault == `FAULT_PERM))
    else $error("fetch allowed without executable flag");

  a_range_low: assert property (
    (st == ST_CHECK && cur.addr <= lbase) |=> (st != ST_ACCESS))
    else $error("address at or below logical base matched");

  a_range_high: assert property (
    (st == ST_CHECK && cur.addr >= trim(lbase + rsize, wide)) |=> (st != ST_ACCESS))
    else $error("address at or above region end matched");

  a_loop_stop: assert property (
    (st == ST_CHECK && !hit && nxt == first_ptr) |=> (done_o && res_o.fault == `FAULT_PAGE))
    else $error("walk went back to the first descriptor");

  a_access_gate: assert property (
    (st == ST_ACCESS && $past(st) != ST_ACCESS)
      |-> (($past(st) == ST_CHECK && $past(hit && perm_ok)) ||
           ($past(st) == ST_IDLE && !$past(page_en))))
    else $error("memory access started without translation");

  a_req_held: assert property (
    (mem_req_o && !mem_ack_i) |=> (mem_req_o && $stable(mem_addr_o)))
    else $error("memory request dropped before acknowledge");

  a_access_result: assert property (
    (st == ST_ACCESS && mem_ack_i)
      |=> (done_o && res_o.fault == `FAULT_NONE && res_o.paddr == $past(mem_addr_o)))
    else $error("access result not reported with done");

  // --------------------------------------------------------------
  // Coverage
  // --------------------------------------------------------------
  c_translated: cover property (st == ST_CHECK && hit && perm_ok ##1 st == ST_ACCESS);
  c_page_fault: cover property (done_o && res_o.fault == `FAULT_PAGE);
  c_perm_fault: cover property (done_o && res_o.fault == `FAULT_PERM);
  c_two_hops:   cover property (st == ST_CHECK && !hit && !chain_end ##1 st == ST_FETCH);
  c_wide_walk:  cover property (st == ST_FETCH && wide && mem_ack_i);

endmodule // paging_translation_unit

// ===== verification/desc_memory.sv
`timescale 1ns/10ps
module desc_memory (
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [63:0] addr_i,
  input  wire logic [63:0] wdata_i,
  input  wire logic [3:0]  delay_i,
  output logic      [63:0] rdata_o,
  output logic             ack_o
);
  logic [63:0] mem [logic [63:0]];
  logic [63:0] seen [$];
  logic        last_we;
  logic [3:0]  wait_cnt;
  // Bus is zero in reset; otherwise it toggles between the last word and its inverse every cycle outside the ack cycle
  always @(posedge sys_clk_i) begin
    if (reset_i || !req_i || ack_o) begin
      ack_o    <= 1'b0;
      wait_cnt <= 4'h0;
      rdata_o  <= reset_i ? 64'h0 : ~rdata_o;
    end else if (wait_cnt >= delay_i) begin
      ack_o   <= 1'b1;
      rdata_o <= mem.exists(addr_i) ? mem[addr_i] : ~addr_i;
      last_we <= we_i;
      seen.push_back(addr_i);
      if (we_i) mem[addr_i] = wdata_i;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
      rdata_o  <= ~rdata_o;
    end
  end
endmodule // desc_memory

// ===== verification/testbench.sv
`timescale 1ns/10ps
`include "ptu_defs.svh"
module testbench
  import ptu_pkg::*;
;
  logic        sys_clk, reset, reg_wr, reg_rd, req_valid, req_ready, done;
  logic        mem_req, mem_we, mem_ack;
  logic [3:0]  reg_addr, delay;
  logic [31:0] reg_wdata, reg_rdata;
  logic [63:0] mem_addr, mem_wdata, mem_rdata;
  xlate_req_t  req;
  xlate_res_t  res;
  int          fail_count, n_checks;
  bit          wide_mode;

  paging_translation_unit i_paging_translation_unit (
    .sys_clk_i(sys_clk), .reset_i(reset), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(reg_rdata), .req_valid_i(req_valid), .req_i(req),
    .req_ready_o(req_ready), .done_o(done), .res_o(res), .mem_req_o(mem_req),
    .mem_we_o(mem_we), .mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata),
    .mem_rdata_i(mem_rdata), .mem_ack_i(mem_ack));
  desc_memory i_desc_memory (
    .sys_clk_i(sys_clk), .reset_i(reset), .req_i(mem_req), .we_i(mem_we),
    .addr_i(mem_addr), .wdata_i(mem_wdata), .delay_i(delay),
    .rdata_o(mem_rdata), .ack_o(mem_ack));

  always #4 sys_clk = ~sys_clk;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic reg_put(logic [3:0] a, logic [31:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_chk(logic [3:0] a, logic [31:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", {32'h0, exp}, {32'h0, reg_rdata});
  endtask
  // Narrow words carry ones above bit 31 so stray upper bits show up
  task automatic put_desc(logic [63:0] at, bit wide, logic [63:0] lb, pb, sz, fl, nx);
    logic [63:0] w [6];
    w = '{lb, pb, sz, fl, nx, 64'h0};
    for (int i = 0; i < 6; i++)
      i_desc_memory.mem[at + 64'(i) * (wide ? 64'h8 : 64'h4)] =
        wide ? w[i] : {32'hffff_ffff, w[i][31:0]};
  endtask
  task automatic xlate(logic [63:0] a, acc_kind_t k, logic [1:0] ef, logic [63:0] ep, int acks);
    logic [63:0] exp_rd;
    // Expected read data is what the memory model holds at the target now
    exp_rd = i_desc_memory.mem.exists(ep) ? i_desc_memory.mem[ep] : ~ep;
    if (!wide_mode) exp_rd = {32'h0, exp_rd[31:0]};
    i_desc_memory.seen.delete();
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req       <= '{addr: a, kind: k, wdata: {32'h0, ~a[31:0]}};
    @(posedge sys_clk);
    req_valid <= 1'b0;
    for (int i = 0; i < 400 && done !== 1'b1; i++)
      @(negedge sys_clk);
    chk("done", 64'h1, {63'h0, done});
    chk("fault", {62'h0, ef}, {62'h0, res.fault});
    chk("mem accesses", 64'(acks), 64'(i_desc_memory.seen.size()));
    if (ef == `FAULT_NONE) begin
      chk("paddr", ep, res.paddr);
      chk("access addr", ep, i_desc_memory.seen[$]);
      chk("access we", {63'h0, k == ACC_WRITE}, {63'h0, i_desc_memory.last_we});
      if (k == ACC_WRITE) chk("wdata", {32'h0, ~a[31:0]}, i_desc_memory.mem[ep]);
      else chk("rdata", exp_rd, res.rdata);
    end
    @(negedge sys_clk);
    chk("done pulse", 64'h0, {63'h0, done});
    chk("req_ready", 64'h1, {63'h0, req_ready});
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    reg_chk(`REG_CTRL, `CTRL_RESET);
    reg_put(`REG_PTR_LO, 32'h0000_0100);
    reg_chk(`REG_PTR_LO, 32'h0000_0100);
    reg_chk(4'h2, 32'h0);
  endtask
  task automatic t_unpaged();
    for (int k = 0; k < 3; k++)
      xlate(64'h1234, acc_kind_t'(k), `FAULT_NONE, 64'h1234, 1);
  endtask
  task automatic t_walk();
    // Chain of two descriptors, loaded before paging is turned on
    put_desc(64'h100, 0, 64'h1000, 64'h2000, 64'h100, 64'h1, 64'h200);
    put_desc(64'h200, 0, 64'h4000, 64'h9000, 64'h1000, 64'h6, 64'h0);
    reg_put(`REG_PTR_HI, 32'h0);
    reg_put(`REG_CTRL, 32'h0000_0010);
    xlate(64'h4010, ACC_READ, `FAULT_NONE, 64'h9010, 11);
    chk("first fetch", 64'h100, i_desc_memory.seen[0]);
    chk("flag word", 64'h10c, i_desc_memory.seen[3]);
    chk("next fetch", 64'h200, i_desc_memory.seen[5]);
    xlate(64'h1001, ACC_READ, `FAULT_NONE, 64'h2001, 6);
    xlate(64'h4000, ACC_READ, `FAULT_PAGE, 64'h0, 10);
    xlate(64'h5000, ACC_READ, `FAULT_PAGE, 64'h0, 10);
    xlate(64'h4fff, ACC_WRITE, `FAULT_NONE, 64'h9fff, 11);
  endtask
  task automatic t_perm();
    logic ok;
    logic [1:0] ef;
    int n;
    for (int f = 0; f < 8; f++) begin
      put_desc(64'h200, 0, 64'h4000, 64'h9000, 64'h1000, 64'(f), 64'h0);
      for (int k = 0; k < 3; k++) begin
        ok = (k == 0) ? (f[0] | f[1]) : (k == 1) ? f[1] : f[2];
        ef = (f[0] & f[1]) | !ok ? `FAULT_PERM : `FAULT_NONE;
        // A faulting lookup never reaches the final access
        n = (ef == `FAULT_NONE) ? 11 : 10;
        xlate(64'h4020, acc_kind_t'(k), ef, 64'h9020, n);
      end
    end
    reg_chk(`REG_STAT, {29'h0, `FAULT_PERM, 1'b0});
  endtask
  task automatic t_loop();
    put_desc(64'h200, 0, 64'h4000, 64'h9000, 64'h1000, 64'h2, 64'h100);
    xlate(64'h7000, ACC_READ, `FAULT_PAGE, 64'h0, 10);
  endtask
  task automatic t_wide();
    delay = 4'h3;
    put_desc(64'h1_0000_0300, 1, 64'h2_0000_0000, 64'h3_0000_0000, 64'h1000, 64'h2, 64'h0);
    reg_put(`REG_PTR_LO, 32'h0000_0300);
    reg_put(`REG_PTR_HI, 32'h0000_0001);
    reg_put(`REG_CTRL, 32'h0000_0011);
    wide_mode = 1'b1;
    xlate(64'h2_0000_0010, ACC_WRITE, `FAULT_NONE, 64'h3_0000_0010, 6);
    chk("wide stride", 64'h1_0000_0308, i_desc_memory.seen[1]);
    xlate(64'h2_0000_0fff, ACC_FETCH, `FAULT_PERM, 64'h0, 5);
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    report_and_stop();
  end

  initial begin
    sys_clk    = 1'b0;
    reset      = 1'b1;
    {reg_wr, reg_rd, req_valid} = 3'h0;
    reg_addr   = 4'h0;
    reg_wdata  = 32'h0;
    req        = '0;
    delay      = 4'h0;
    fail_count = 0;
    n_checks   = 0;
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    t_regs();
    t_unpaged();
    t_walk();
    t_perm();
    t_loop();
    t_wide();
    report_and_stop();
  end
endmodule // testbench
